/* verilog/spipc_top.sv */
// sixteen-port i/o expander with pulse, frequency and duty measurement
// assumes pins are asynchronous to clock and the bus master obeys AXI4-Lite
`timescale 1ns/1ps
module spipc_top #(
    parameter int unsigned MIN_TICKS_P = spipc_pkg::MIN_TICKS,
    parameter int unsigned DEB_TICKS_P = spipc_pkg::DEBOUNCE_TICKS
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // register bus
    input  wire spipc_pkg::spipc_axi_req_t       axiReq,
    output      spipc_pkg::spipc_axi_rsp_t       axiRsp,
    // port pins
    input  wire logic [spipc_pkg::NUM_PORTS-1:0] portIn,
    output      logic [spipc_pkg::NUM_PORTS-1:0] portOut,
    output      logic [spipc_pkg::NUM_PORTS-1:0] portOe,
    // address selector and change line
    input  wire logic [3:0]                      moduleSel,
    output      logic                            changeIrq
);
    import spipc_pkg::*;

    // ----------------------------------------------------------------
    // state and bus decode shared with the checks
    // ----------------------------------------------------------------
    spipc_state_t         st;
    spipc_state_t         next_st;
    logic                 doWrite;
    logic                 cmdWr;
    logic                 cmdBad;
    logic                 cmdMine;
    logic                 capFreq;
    logic                 capDuty;
    logic [NUM_PORTS-1:0] cmdMask;
    logic [NUM_PORTS-1:0] changed;

    // a write completes once address and data have both been taken
    assign doWrite = st.awHave && st.wHave && !st.rsp.bvalid;
    assign cmdWr   = doWrite && st.awAddr == OFF_CMD && st.wStrb == 4'hF;
    assign cmdBad  = cmdWr && st.wData[CMD_CHK_LSB +: 4] != cmdCheck(st.wData);
    assign cmdMine = cmdWr && !cmdBad && st.wData[CMD_ADDR_LSB +: 4] == st.selSync;
    assign cmdMask = groupMask(st.wData[CMD_START_LSB +: 4], st.wData[CMD_GRP_LSB +: 2]);
    assign capFreq = doWrite && st.awAddr == OFF_CAPTURE && st.wStrb == 4'hF && !st.wData[CAP_KIND_BIT];
    assign capDuty = doWrite && st.awAddr == OFF_CAPTURE && st.wStrb == 4'hF && st.wData[CAP_KIND_BIT];

    // outputs straight from the state flops
    assign axiRsp    = st.rsp;
    assign portOut   = st.level;
    assign portOe    = st.dir;
    assign changeIrq = st.changePend;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        spipc_chan_t          c;
        logic                 fell;
        logic                 restartF;
        logic                 restartD;
        logic [24:0]          sum;
        logic [NUM_PORTS-1:0] levels;
        logic [23:0]          rv;
        c        = '0;
        fell     = 1'b0;
        restartF = 1'b0;
        restartD = 1'b0;
        sum      = '0;
        levels   = '0;
        rv       = '0;
        changed  = '0;
        next_st  = st;

        // 1 us timebase: slow enough for 24-bit spans, fine enough for 4 kHz duty
        if (st.tickDiv == 5'(TICK_CYCLES - 1)) begin
            next_st.tickDiv = '0;
            next_st.tick    = 1'b1;
        end else begin
            next_st.tickDiv = st.tickDiv + 5'd1;
            next_st.tick    = 1'b0;
        end

        // selector pins pass two flops before use
        next_st.selMeta = moduleSel;
        next_st.selSync = st.selMeta;

        // bus handshakes retire before new work is taken
        if (st.rsp.bvalid && axiReq.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (st.rsp.rvalid && axiReq.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (axiReq.awvalid && st.rsp.awready) begin
            next_st.awHave = 1'b1;
            next_st.awAddr = {axiReq.awaddr[11:2], 2'b00};
        end
        if (axiReq.wvalid && st.rsp.wready) begin
            next_st.wHave = 1'b1;
            next_st.wData = axiReq.wdata;
            next_st.wStrb = axiReq.wstrb;
        end

        // register writes; status clears come before the event sets below
        if (doWrite) begin
            next_st.awHave     = 1'b0;
            next_st.wHave      = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp  = RESP_OKAY;
            case (st.awAddr)
                OFF_CMD: begin
                    if (cmdBad) begin
                        next_st.cmdErr = 1'b1;
                    end else if (cmdMine) begin
                        // per-port data bits land only inside the coded group
                        unique case (spipc_op_t'(st.wData[CMD_OP_LSB +: 2]))
                            OP_DIR:      next_st.dir   = (st.dir & ~cmdMask) | (st.wData[31:16] & cmdMask);
                            OP_LEVEL:    next_st.level = (st.level & ~cmdMask) | (st.wData[31:16] & cmdMask);
                            OP_DEBOUNCE: next_st.debEn = (st.debEn & ~cmdMask) | (st.wData[31:16] & cmdMask);
                            OP_WATCH:    next_st.watch = (st.watch & ~cmdMask) | (st.wData[31:16] & cmdMask);
                        endcase
                    end
                end
                OFF_STATUS: begin
                    if (st.wStrb[2] && st.wData[ST_ERR_BIT]) begin
                        next_st.cmdErr = 1'b0;
                    end
                    if (st.wStrb[2] && st.wData[ST_CHG_BIT]) begin
                        next_st.changePend = 1'b0;
                    end
                end
                OFF_DEBOUNCE: begin
                    if (st.wStrb[0]) next_st.debTime[7:0] = st.wData[7:0];
                    if (st.wStrb[1]) next_st.debTime[15:8] = st.wData[15:8];
                end
                OFF_CAPTURE: begin
                    // snapshot the running sums; the channel restarts below
                    if (capFreq) begin
                        next_st.resA      = st.ch[st.wData[3:0]].freqTime;
                        next_st.resB      = {8'h00, st.ch[st.wData[3:0]].intervals};
                        next_st.resPulses = st.ch[st.wData[3:0]].pulses;
                    end
                    if (capDuty) begin
                        next_st.resA = st.ch[st.wData[3:0]].highTime;
                        next_st.resB = st.ch[st.wData[3:0]].totalTime;
                    end
                end
                OFF_RES_A, OFF_RES_B, OFF_PULSES, OFF_DIR, OFF_LEVEL, OFF_DEBEN, OFF_WATCH: begin
                end
                default: next_st.rsp.bresp = RESP_SLVERR;
            endcase
        end

        // per-channel input path
        for (int i = 0; i < NUM_PORTS; i++) begin
            c        = st.ch[i];
            restartF = capFreq && st.wData[3:0] == 4'(i);
            restartD = capDuty && st.wData[3:0] == 4'(i);
            if (restartF) begin
                c.freqTime  = '0;
                c.intervals = '0;
                c.pulses    = '0;
                // forget the last fall so one fall alone reads as 0 Hz
                c.fallSeen  = 1'b0;
            end
            // duty sums restart only on their own request
            if (restartD) begin
                c.highTime  = '0;
                c.totalTime = '0;
            end
            c.meta = portIn[i];
            c.sync = st.ch[i].meta;

            // a new level is accepted only after it held the minimum width
            if (st.tick) begin
                if (st.ch[i].sync == st.ch[i].filt) begin
                    c.stab = '0;
                end else if (st.ch[i].stab >= 12'(MIN_TICKS_P - 1)) begin
                    c.filt = st.ch[i].sync;
                    c.stab = '0;
                end else begin
                    c.stab = st.ch[i].stab + 12'd1;
                end
            end
            fell       = st.ch[i].filt && !c.filt;
            changed[i] = st.ch[i].filt != c.filt;
            levels[i]  = st.ch[i].filt;

            // contact debounce: both closed and open spells must last debTime
            if (!st.debEn[i]) begin
                c.deb    = c.filt;
                c.debCnt = '0;
            end else if (st.ch[i].filt == st.ch[i].deb) begin
                c.debCnt = '0;
            end else if (st.tick) begin
                if (st.debTime <= 16'd1 || st.ch[i].debCnt >= st.debTime - 16'd1) begin
                    c.deb    = st.ch[i].filt;
                    c.debCnt = '0;
                end else begin
                    c.debCnt = st.ch[i].debCnt + 16'd1;
                end
            end
            // a closure counts when the contact reopens
            if (!st.ch[i].deb && c.deb && c.pulses != 16'hFFFF) begin
                c.pulses = c.pulses + 16'd1;
            end

            // duty: high time over total time, both saturating
            if (st.tick && c.totalTime != 24'hFFFFFF) begin
                c.totalTime = c.totalTime + 24'd1;
                if (st.ch[i].filt) begin
                    c.highTime = c.highTime + 24'd1;
                end
            end

            // frequency: sum of spans between falling edges and their count
            if (st.tick && c.sinceFall != 24'hFFFFFF) begin
                c.sinceFall = st.ch[i].sinceFall + 24'd1;
            end
            if (fell) begin
                // the span ends on this tick, so use the count that includes it
                if (c.fallSeen) begin
                    sum         = {1'b0, c.freqTime} + {1'b0, c.sinceFall};
                    c.freqTime  = sum[24] ? 24'hFFFFFF : sum[23:0];
                    c.intervals = (c.intervals == 16'hFFFF) ? c.intervals : c.intervals + 16'd1;
                end
                c.sinceFall = '0;
                c.fallSeen  = 1'b1;
            end
            next_st.ch[i] = c;
        end

        // enabled inputs that change raise the change line; set beats clear
        if (|(changed & st.watch)) begin
            next_st.changePend = 1'b1;
        end

        // register reads
        if (axiReq.arvalid && st.rsp.arready) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp  = RESP_OKAY;
            next_st.rsp.rdata  = '0;
            case ({axiReq.araddr[11:2], 2'b00})
                OFF_CMD, OFF_CAPTURE: next_st.rsp.rdata = '0;
                OFF_STATUS:   next_st.rsp.rdata = {14'h0000, st.changePend, st.cmdErr, levels};
                OFF_DEBOUNCE: next_st.rsp.rdata = {16'h0000, st.debTime};
                OFF_RES_A:    next_st.rsp.rdata = {resCheck(st.resA), 4'h0, st.resA};
                OFF_RES_B:    next_st.rsp.rdata = {resCheck(st.resB), 4'h0, st.resB};
                OFF_PULSES: begin
                    rv                = {8'h00, st.resPulses};
                    next_st.rsp.rdata = {resCheck(rv), 4'h0, rv};
                end
                OFF_DIR:      next_st.rsp.rdata = {16'h0000, st.dir};
                OFF_LEVEL:    next_st.rsp.rdata = {16'h0000, st.level};
                OFF_DEBEN:    next_st.rsp.rdata = {16'h0000, st.debEn};
                OFF_WATCH:    next_st.rsp.rdata = {12'h000, st.selSync, st.watch};
                default:      next_st.rsp.rresp = RESP_SLVERR;
            endcase
        end

        // ready flags are flops, one write and one read in flight
        next_st.rsp.awready = !next_st.awHave && !next_st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.wHave && !next_st.rsp.bvalid;
        next_st.rsp.arready = !next_st.rsp.rvalid;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st         <= '0;
            st.debTime <= 16'(DEB_TICKS_P);
            // pins idle high through their bias, so start filters there
            for (int i = 0; i < NUM_PORTS; i++) begin
                st.ch[i].meta <= 1'b1;
                st.ch[i].sync <= 1'b1;
                st.ch[i].filt <= 1'b1;
                st.ch[i].deb  <= 1'b1;
            end
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_filter_width: assert property ($changed(st.ch[0].filt) |->
        $past(st.tick) && $past(st.ch[0].stab) == 12'(MIN_TICKS_P - 1))
        else $error("filtered level moved before minimum width");
    chk_debounce_wait: assert property (st.debEn[0] && $past(st.debEn[0]) && $changed(st.ch[0].deb) |->
        $past(st.tick) && ($past(st.debTime) <= 16'd1 || $past(st.ch[0].debCnt) >= $past(st.debTime) - 16'd1))
        else $error("debounced level moved early");
    chk_freq_zero: assert property ($past(capFreq) && st.resB == '0 |->
        st.resA == '0)
        else $error("frequency span reported without two falling edges");
    chk_capture_restart: assert property (capFreq |=> st.ch[$past(st.wData[3:0])].intervals == 16'd0)
        else $error("channel did not restart after request");
    chk_change_line: assert property ($rose(st.changePend) |->
        $past(|(changed & st.watch)))
        else $error("change line raised without watched change");
    chk_cmd_reject: assert property (cmdBad |=> st.cmdErr && $stable(st.dir) && $stable(st.level))
        else $error("corrupted command not flagged or applied");
    chk_addr_select: assert property (cmdWr && st.wData[CMD_ADDR_LSB +: 4] != st.selSync |=>
        $stable(st.dir) && $stable(st.level) && $stable(st.debEn) && $stable(st.watch))
        else $error("command for another module applied");
    chk_group_span: assert property (cmdMine |=> ((st.dir ^ $past(st.dir)) & ~$past(cmdMask)) == '0)
        else $error("command touched ports outside its group");
    chk_reset_inputs: assert property (@(posedge clock) disable iff (1'b0) rst |=>
        st.dir == '0 && st.debEn == '0 && portOe == '0)
        else $error("ports not inputs without debounce after reset");
    chk_bresp_hold: assert property (st.rsp.bvalid && !axiReq.bready |=> st.rsp.bvalid && $stable(st.rsp.bresp))
        else $error("write response dropped before taken");
    // channel 0 stands for all sixteen
    chk_count_edge: assert property ($changed(st.ch[0].pulses) && st.ch[0].pulses != '0 |->
        $rose(st.ch[0].deb))
        else $error("count without rise");
    chk_duty_bound: assert property (st.ch[0].highTime <= st.ch[0].totalTime)
        else $error("high time above total");
    chk_tick_single: assert property (st.tick |=> !st.tick)
        else $error("long tick");
    // commands land as written and clears take effect
    chk_level_apply: assert property (cmdMine && st.wData[CMD_OP_LSB +: 2] == OP_LEVEL |=>
        (st.level & $past(cmdMask)) == ($past(st.wData[31:16]) & $past(cmdMask)))
        else $error("commanded level not applied");
    chk_err_clear: assert property (doWrite && st.awAddr == OFF_STATUS &&
        st.wStrb[2] && st.wData[ST_ERR_BIT] |=> !st.cmdErr)
        else $error("command error not cleared");

    // main scenarios the bench should reach
    cov_freq_capture: cover property (capFreq ##1 st.resB > 24'd1);
    cov_duty_capture: cover property (capDuty ##1 st.resA < st.resB);
    cov_cmd_error: cover property (cmdBad ##1 st.cmdErr);
    cov_change_line: cover property ($rose(changeIrq));
    cov_debounced_count: cover property (st.debEn[0] && $changed(st.ch[0].pulses));

endmodule

/* common/spipc_pkg.sv */
// constants, carriers and state layout of the sixteen-port i/o pulse counter
// assumes a single 20 MHz clock and an AXI4-Lite master on the register side
//
// Behaviour
// - sixteen ports, each input or output
// - inputs report level, count, frequency, duty
// - selectable debounce filter for pulse counting
// - frequency from time between falling edges
// - enabled input changes raise change line
// - outputs drive low or high on command
// - module address selects; 256 ports overall
// - transfers carry checks; receivers detect corruption; here only command writes and result reads carry a check nibble
// - count 2.048 kHz on all channels undebounced
// - count 150 Hz with default debounce
// - under two falling edges reports 0 Hz
// - level must hold 244 us to count
// - debounce 3.17 ms closed/open, adjustable
// - separate intervals per channel and kind
// - duty cycle averaged up to 4 kHz; duty uses the 244 us filtered level here, so 2.048 kHz at most
// - reset: inputs, no debounce, measuring
// - sixteen-position address selector, default zero
// - commands act on 1/4/8/16 ports
package spipc_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int NUM_PORTS       = 16;
    localparam int CLK_NS          = 50;
    localparam int TICK_NS         = 1000;
    localparam int TICK_CYCLES     = TICK_NS / CLK_NS;
    localparam int MIN_PULSE_NS    = 244000;
    localparam int MIN_TICKS       = (MIN_PULSE_NS + TICK_NS - 1) / TICK_NS;
    localparam int DEBOUNCE_NS     = 3170000;
    localparam int DEBOUNCE_TICKS  = (DEBOUNCE_NS + TICK_NS - 1) / TICK_NS;
    // 15.9375 s in ticks still fits the 24-bit accumulators
    localparam int MAX_INTERVAL_US = 15937500;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CMD      = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    localparam logic [11:0] OFF_DEBOUNCE = 12'h008;
    localparam logic [11:0] OFF_CAPTURE  = 12'h00C;
    localparam logic [11:0] OFF_RES_A    = 12'h010;
    localparam logic [11:0] OFF_RES_B    = 12'h014;
    localparam logic [11:0] OFF_PULSES   = 12'h018;
    localparam logic [11:0] OFF_DIR      = 12'h01C;
    localparam logic [11:0] OFF_LEVEL    = 12'h020;
    localparam logic [11:0] OFF_DEBEN    = 12'h024;
    localparam logic [11:0] OFF_WATCH    = 12'h028;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMD_START_LSB = 0;
    localparam int CMD_GRP_LSB   = 4;
    localparam int CMD_OP_LSB    = 6;
    localparam int CMD_ADDR_LSB  = 8;
    localparam int CMD_CHK_LSB   = 12;
    localparam int CMD_DATA_LSB  = 16;
    localparam int ST_ERR_BIT    = 16;
    localparam int ST_CHG_BIT    = 17;
    localparam int CAP_KIND_BIT  = 4;
    localparam int RES_CHK_LSB   = 28;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_DIR = 2'h0, OP_LEVEL = 2'h1, OP_DEBOUNCE = 2'h2, OP_WATCH = 2'h3} spipc_op_t;

    // ----------------------------------------------------------------
    // carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        awvalid; logic [11:0] awaddr;
        logic        wvalid;  logic [31:0] wdata; logic [3:0] wstrb;
        logic        bready;
        logic        arvalid; logic [11:0] araddr;
        logic        rready;
    } spipc_axi_req_t;

    typedef struct packed {
        logic        awready; logic wready;
        logic        bvalid;  logic [1:0] bresp;
        logic        arready;
        logic        rvalid;  logic [31:0] rdata; logic [1:0] rresp;
    } spipc_axi_rsp_t;

    typedef struct packed {
        logic meta; logic sync; logic filt; logic [11:0] stab;
        logic deb;  logic [15:0] debCnt; logic [15:0] pulses;
        logic [23:0] sinceFall; logic fallSeen; logic [15:0] intervals;
        logic [23:0] freqTime; logic [23:0] highTime; logic [23:0] totalTime;
    } spipc_chan_t;

    typedef struct packed {
        spipc_chan_t [NUM_PORTS-1:0] ch;
        logic [4:0]  tickDiv; logic tick;
        logic [NUM_PORTS-1:0] dir; logic [NUM_PORTS-1:0] level;
        logic [NUM_PORTS-1:0] debEn; logic [NUM_PORTS-1:0] watch;
        logic [15:0] debTime;
        logic [3:0]  selMeta; logic [3:0] selSync;
        logic        cmdErr; logic changePend;
        logic [23:0] resA; logic [23:0] resB; logic [15:0] resPulses;
        logic        awHave; logic [11:0] awAddr;
        logic        wHave;  logic [31:0] wData; logic [3:0] wStrb;
        spipc_axi_rsp_t rsp;
    } spipc_state_t;

    // check nibble over every nibble of a command except the check itself
    function automatic logic [3:0] cmdCheck(input logic [31:0] w);
        cmdCheck = w[3:0] ^ w[7:4] ^ w[11:8] ^ w[19:16] ^ w[23:20] ^ w[27:24] ^ w[31:28];
    endfunction

    // check nibble returned with each 24-bit result
    function automatic logic [3:0] resCheck(input logic [23:0] v);
        resCheck = v[3:0] ^ v[7:4] ^ v[11:8] ^ v[15:12] ^ v[19:16] ^ v[23:20];
    endfunction

    // group of 1, 4, 8 or 16 ports aligned on its own size
    function automatic logic [NUM_PORTS-1:0] groupMask(input logic [3:0] start, input logic [1:0] grp);
        unique case (grp)
            2'h0: groupMask = 16'h0001 << start;
            2'h1: groupMask = 16'h000F << {start[3:2], 2'b00};
            2'h2: groupMask = 16'h00FF << {start[3], 3'b000};
            2'h3: groupMask = 16'hFFFF;
        endcase
    endfunction

endpackage

/* test/spipc_pulse_src.sv */
// pin-side source: square pulses on one input port
// assumes start is raised for one cycle while busy is low
`timescale 1ns/1ps
module spipc_pulse_src (
    // clock and control
    input  wire logic        clock,
    input  wire logic        start,
    input  wire logic [15:0] halfCyc,
    input  wire logic [7:0]  pulses,
    // pin and status
    output      logic        pin,
    output      logic        busy
);
    // idles high like a biased open input
    initial begin
        pin = 1'b1;
        busy = 1'b0;
    end
    // each pulse is a high half then a low half
    always @(posedge clock) begin
        if (start && !busy) begin
            busy <= 1'b1;
            repeat (pulses) begin
                repeat (halfCyc) @(posedge clock);
                pin <= 1'b0;
                repeat (halfCyc) @(posedge clock);
                pin <= 1'b1;
            end
            busy <= 1'b0;
        end
    end
endmodule

/* test/tb_top.sv */
// bench: AXI4-Lite master, pin source and integer model of counts
// assumes the package is compiled first; short filter counts
`timescale 1ns/1ps
module tb_top;
    import spipc_pkg::*;
    logic           clock, rst, go, srcPin, busy, changeIrq;
    logic [3:0]     sel;
    logic [15:1]    oth;
    logic [15:0]    half, portOut, portOe;
    logic [7:0]     num;
    logic [31:0]    d, w;
    logic [1:0]     r;
    int             seed, failures, compares, k;
    spipc_axi_req_t req;
    spipc_axi_rsp_t rsp;
    wire [15:0]     portIn = {oth, srcPin};
    spipc_top #(.MIN_TICKS_P(4), .DEB_TICKS_P(8)) dut (.clock(clock), .rst(rst), .axiReq(req), .axiRsp(rsp),
        .portIn(portIn), .portOut(portOut), .portOe(portOe), .moduleSel(sel), .changeIrq(changeIrq));
    spipc_pulse_src src (.clock(clock), .start(go), .halfCyc(half), .pulses(num), .pin(srcPin), .busy(busy));
    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n >= 500) begin
            failures++;
            $display("wrong value at %0t: no answer", $time);
            wrap_up();
        end
    endtask
    // bready and rready stay high, so every answer is taken where seen
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= v;
        do begin
            @(posedge clock);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            n++;
        end while (!rsp.bvalid && n < 500);
        hang(n);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge clock);
            if (rsp.arready) req.arvalid <= 1'b0;
            n++;
        end while (!rsp.rvalid && n < 500);
        hang(n);
        v = rsp.rdata;
        e = rsp.rresp;
    endtask
    // command word with its check nibble worked out here
    function automatic logic [31:0] mk(input logic [3:0] s, input logic [1:0] g, input logic [1:0] op,
                                       input logic [3:0] ad, input logic [15:0] v);
        logic [31:0] c;
        c = {v, 4'h0, ad, op, g, s};
        c[15:12] = c[3:0] ^ c[7:4] ^ c[11:8] ^ c[19:16] ^ c[23:20] ^ c[27:24] ^ c[31:28];
        return c;
    endfunction
    // pulses, then a settle long enough for filter and debounce
    task automatic pulse(input logic [15:0] h, input logic [7:0] p);
        int n;
        n = 0;
        half <= h;
        num <= p;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (busy && n < 20000);
        hang(n / 40);
        repeat (300) @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        seed = 32'hC5978570;
        failures = 0;
        compares = 0;
        {rst, go, half, num} = {1'b1, 1'b0, 16'h0004, 8'h00};
        req = '0;
        {req.wstrb, req.bready, req.rready} = {4'hF, 1'b1, 1'b1};
        sel = 4'($random(seed));
        oth = 15'($random(seed));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (100) @(posedge clock);
        chk(32'(portOe), 32'h0);
        rd(OFF_DEBOUNCE, d, r);
        chk(d, 32'h8);
        rd(12'h100, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(OFF_STATUS, d, r);
        chk(32'(d[15:0]), 32'({oth, 1'b1}));
        $display("test defaults done");
        w = 32'($random(seed));
        wr(OFF_CMD, mk(4'h5, 2'h1, OP_DIR, sel, w[15:0]));
        wr(OFF_CMD, mk(4'h0, 2'h3, OP_DIR, sel ^ 4'h1, 16'hFFFF));
        wr(OFF_CMD, mk(4'h0, 2'h3, OP_DIR, sel, 16'hFFFF) ^ 32'h00001000);
        wr(OFF_CMD, mk(4'h0, 2'h3, OP_LEVEL, sel, w[31:16]));
        chk(32'(portOe), 32'(w[15:0] & 16'h00F0));
        chk(32'(portOut), 32'(w[31:16]));
        rd(OFF_STATUS, d, r);
        chk(32'(d[16]), 32'h1);
        $display("test outputs done");
        k = 6;
        wr(OFF_CAPTURE, 32'h0);
        wr(OFF_CAPTURE, 32'h10);
        pulse(16'h00C8, 8'(k));
        pulse(16'h0004, 8'h08);
        wr(OFF_CAPTURE, 32'h0);
        rd(OFF_PULSES, d, r);
        chk(32'(d[15:0]), 32'(k));
        rd(OFF_RES_B, d, r);
        chk(d[23:0], 32'(k - 1));
        rd(OFF_RES_A, d, r);
        chk(d, {4'h2, 4'h0, 24'((k - 1) * 20)});
        wr(OFF_CAPTURE, 32'h10);
        rd(OFF_RES_A, d, r);
        rd(OFF_RES_B, w, r);
        chk(32'(w[23:0] - d[23:0]), 32'(k * 10));
        wr(OFF_CAPTURE, 32'h0);
        rd(OFF_RES_B, d, r);
        chk(d, 32'h0);
        rd(OFF_RES_A, d, r);
        chk(d, 32'h0);
        $display("test counting done");
        wr(OFF_CMD, mk(4'h0, 2'h0, OP_DEBOUNCE, sel, 16'h0001));
        wr(OFF_CAPTURE, 32'h0);
        pulse(16'h0078, 8'h03);
        pulse(16'h00C8, 8'h04);
        wr(OFF_CAPTURE, 32'h0);
        rd(OFF_PULSES, d, r);
        chk(32'(d[15:0]), 32'h4);
        wr(OFF_CMD, mk(4'h0, 2'h0, OP_WATCH, sel, 16'h0001));
        chk(32'(changeIrq), 32'h0);
        pulse(16'h00C8, 8'h01);
        chk(32'(changeIrq), 32'h1);
        wr(OFF_CAPTURE, 32'h0);
        rd(OFF_RES_B, d, r);
        chk(d, 32'h0);
        wr(OFF_STATUS, 32'h00030000);
        rd(OFF_STATUS, d, r);
        chk(32'({changeIrq, d[17:16]}), 32'h0);
        $display("test debounce and change done");
        wrap_up();
    end
endmodule
